// file: csb_bit_pick.v
// Selects one bit of a byte by a three-bit index.
module csb_bit_pick (
  // Source byte and index.
  input  wire [7:0] data,
  input  wire [2:0] sel,
  // Chosen bit.
  output wire       bit_out
);
  // Plain multiplexer on the index.
  assign bit_out = data[sel];
endmodule

// file: csb_cond_ctrl.v
// Conditional skip and branch control unit of an 8-bit core.
// How it works
// [RULE1] Register bit one skips next instruction.
// [RULE2] I/O bit clear skips next instruction.
// [RULE3] I/O bit set skips next instruction.
// [RULE4] Flag set branches to PC plus k plus one.
// [RULE5] Flag clear branches to PC plus k plus one.
// [RULE6] Skip and branch never change the status flags; only an outside write in idle loads them.
`include "csb_defs.vh"
module csb_cond_ctrl (
  // Clock and reset.
  input  wire        clk,
  input  wire        rst_n,
  // Instruction request, one-cycle strobe.
  input  wire        instr_valid,
  input  wire [2:0]  instr_op,
  input  wire [2:0]  bit_sel,
  input  wire [6:0]  offset_k,
  input  wire        next_is_long,
  // Operand sources.
  input  wire [7:0]  gp_reg_data,
  input  wire [7:0]  io_reg_data,
  input  wire [7:0]  flags_in,
  input  wire        flags_we,
  // Results.
  output reg  [15:0] pc,
  output reg  [7:0]  status_flags_register,
  output reg         busy,
  output reg         done,
  output reg         taken
);
  // One-hot sequencer states.
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_LAST = 3'b100;

  // Picker slots for the three operand sources.
  localparam SRC_GP = 0;
  localparam SRC_IO = 1;
  localparam SRC_FL = 2;
  localparam N_SRC  = 3;

  // Sequencer state and its next value.
  reg  [2:0]         state;
  reg  [2:0]         next_state;
  // Decoded outcome of the instruction on the request lines.
  reg                next_taken;
  reg  [15:0]        next_pc;
  reg  [1:0]         extra;
  // Target held while a taken instruction spends its extra cycles.
  reg  [15:0]        target_pc;
  // Sign-extended branch offset.
  wire [15:0]        offset_ext;
  // Picker inputs and the picked bits.
  wire [8*N_SRC-1:0] pick_src;
  wire [N_SRC-1:0]   pick_bit;
  wire               gp_bit;
  wire               io_bit;
  wire               fl_bit;
  // A new instruction is taken in this cycle.
  wire               accept;

  // True for the two flag branch opcodes.
  function op_is_branch;
    input [2:0] op;
    begin
      op_is_branch = (op == `CSB_OP_BR_SET) || (op == `CSB_OP_BR_CLR);
    end
  endfunction

  // True for the three bit skip opcodes.
  function op_is_skip;
    input [2:0] op;
    begin
      op_is_skip = (op == `CSB_OP_SKIP_REG) || (op == `CSB_OP_SKIP_IOC) || (op == `CSB_OP_SKIP_IOS);
    end
  endfunction

  // The 7-bit offset reaches backwards as well as forwards.
  assign offset_ext = {{9{offset_k[6]}}, offset_k};

  // Only the idle state takes a request; one that arrives while busy is dropped
  // without any indication, so the issuing side must wait for done.
  assign accept = instr_valid && (state == ST_IDLE);

  // The flags feed the picker as they stand before this instruction.
  assign pick_src = {status_flags_register, io_reg_data, gp_reg_data};

  // One bit picker per operand source.
  genvar gi;
  generate
    for (gi = 0; gi < N_SRC; gi = gi + 1) begin : g_pick
      csb_bit_pick u_pick (
        .data    (pick_src[8*gi +: 8]),
        .sel     (bit_sel),
        .bit_out (pick_bit[gi])
      );
    end
  endgenerate

  // Named views of the picked bits.
  assign gp_bit = pick_bit[SRC_GP];
  assign io_bit = pick_bit[SRC_IO];
  assign fl_bit = pick_bit[SRC_FL];

  // Condition of the instruction on the request lines.
  always @* begin
    next_taken = 1'b0;
    case (instr_op)
      `CSB_OP_SKIP_REG: next_taken = gp_bit;   // see [RULE1]
      `CSB_OP_SKIP_IOC: next_taken = ~io_bit;  // see [RULE2]
      `CSB_OP_SKIP_IOS: next_taken = io_bit;   // see [RULE3]
      `CSB_OP_BR_SET:   next_taken = fl_bit;   // see [RULE4]
      `CSB_OP_BR_CLR:   next_taken = ~fl_bit;  // see [RULE5]
      default:          next_taken = 1'b0;
    endcase
  end

  // Target and cost; a not-taken instruction just steps to the next word.
  always @* begin
    next_pc = pc + `CSB_PC_STEP;
    extra   = `CSB_COST_NONE;
    if (next_taken && op_is_branch(instr_op)) begin
      // A taken branch costs one extra cycle.
      next_pc = pc + offset_ext + `CSB_PC_STEP;  // see [RULE4] see [RULE5]
      extra   = `CSB_COST_ONE;
    end else if (next_taken && op_is_skip(instr_op) && next_is_long) begin
      // Skipping a two-word instruction costs two extra cycles.
      next_pc = pc + `CSB_SKIP_LONG;  // see [RULE1] see [RULE2] see [RULE3]
      extra   = `CSB_COST_TWO;
    end else if (next_taken && op_is_skip(instr_op)) begin
      // Skipping a one-word instruction costs one extra cycle.
      next_pc = pc + `CSB_SKIP_SHORT;  // see [RULE1] see [RULE2] see [RULE3]
      extra   = `CSB_COST_ONE;
    end else begin
      next_pc = pc + `CSB_PC_STEP;
      extra   = `CSB_COST_NONE;
    end
  end

  // Sequencer: idle, then one wait cycle for a long skip, then the last cycle.
  always @* begin
    next_state = ST_IDLE;
    case (state)
      ST_IDLE: begin
        if (accept && (extra == `CSB_COST_TWO)) begin
          next_state = ST_WAIT;
        end else if (accept && (extra == `CSB_COST_ONE)) begin
          next_state = ST_LAST;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_WAIT: next_state = ST_LAST;
      ST_LAST: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // Sequencer state register.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // The target waits here until the last cycle of a taken instruction.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      target_pc <= `CSB_PC_RESET;
    end else if (accept && (extra != `CSB_COST_NONE)) begin
      target_pc <= next_pc;
    end
  end

  // The program counter moves at once when the instruction is not taken, otherwise in the last
  // cycle, so a taken instruction never shows a half-way value.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc <= `CSB_PC_RESET;
    end else if (accept && (extra == `CSB_COST_NONE)) begin
      pc <= next_pc;
    end else if (state == ST_LAST) begin
      pc <= target_pc;
    end
  end

  // Busy covers every cycle after acceptance except the one that ends the instruction.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= (next_state != ST_IDLE);
    end
  end

  // Done pulses for one cycle as the instruction ends.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else begin
      done <= (accept && (extra == `CSB_COST_NONE)) || (state == ST_LAST);
    end
  end

  // Taken holds the outcome of the last instruction until the next one is accepted.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      taken <= 1'b0;
    end else if (accept) begin
      taken <= next_taken;
    end
  end

  // Flags change only on an outside write in idle, never by skip or branch;
  // a write beside a request or during one is dropped.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_flags_register <= `CSB_STATUS_FLAGS_REGISTER_RESET;
    end else if (flags_we && state == ST_IDLE && !instr_valid) begin
      status_flags_register <= flags_in;  // see [RULE6]
    end
  end
endmodule

// file: csb_defs.vh
// Constants for the conditional skip and branch unit.
`ifndef CSB_DEFS_VH
`define CSB_DEFS_VH
`define CSB_OP_NONE     3'h0
`define CSB_OP_SKIP_REG 3'h1
`define CSB_OP_SKIP_IOC 3'h2
`define CSB_OP_SKIP_IOS 3'h3
`define CSB_OP_BR_SET   3'h4
`define CSB_OP_BR_CLR   3'h5
`define CSB_SKIP_SHORT  16'h0002
`define CSB_SKIP_LONG   16'h0003
`define CSB_PC_STEP     16'h0001
`define CSB_PC_RESET    16'h0000
`define CSB_STATUS_FLAGS_REGISTER_RESET  8'h00
`define CSB_COST_NONE   2'h0
`define CSB_COST_ONE    2'h1
`define CSB_COST_TWO    2'h2
`endif

// file: csb_monitor.sv
// Checker of cycle cost, target and flag stability of the skip and branch unit.
module csb_monitor (
  // Clock, reset and request.
  input logic        clk,
  input logic        rst_n,
  input logic        instr_valid,
  input logic [2:0]  instr_op,
  input logic [2:0]  bit_sel,
  input logic [6:0]  offset_k,
  input logic        next_is_long,
  // Operands and results.
  input logic [7:0]  gp_reg_data,
  input logic [7:0]  io_reg_data,
  input logic [7:0]  status_flags_register,
  input logic [15:0] pc,
  input logic        busy,
  input logic        done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Accepted request, its opcode and the widened offset plus one.
  wire        q  = instr_valid && !busy;
  wire [2:0]  o  = instr_op;
  wire [15:0] kx = {{9{offset_k[6]}}, offset_k} + 16'h1;
  property p_a; q && o == 3'h1 && gp_reg_data[bit_sel] && next_is_long |-> ##3 (done && pc == $past(pc, 3) + 16'h3); endproperty
  a_a: assert property (p_a) else $error("register skip wrong");
  property p_b; q && o == 3'h2 && !io_reg_data[bit_sel] && !next_is_long |-> ##2 (done && pc == $past(pc, 2) + 16'h2); endproperty
  a_b: assert property (p_b) else $error("clear skip wrong");
  property p_c; q && o == 3'h3 && !io_reg_data[bit_sel] |=> (done && pc == $past(pc) + 16'h1); endproperty
  a_c: assert property (p_c) else $error("set skip wrong");
  property p_d; q && o == 3'h4 && status_flags_register[bit_sel] |=> busy ##1 (done && pc == $past(pc, 2) + $past(kx, 2)); endproperty
  a_d: assert property (p_d) else $error("set branch wrong");
  property p_e; q && o == 3'h5 && !status_flags_register[bit_sel] |=> busy ##1 (done && pc == $past(pc, 2) + $past(kx, 2)); endproperty
  a_e: assert property (p_e) else $error("clear branch wrong");
  property p_f; busy || instr_valid |=> $stable(status_flags_register); endproperty
  a_f: assert property (p_f) else $error("flags changed");
endmodule
bind csb_cond_ctrl csb_monitor csb_monitor_i (
  .clk                   (clk),
  .rst_n                 (rst_n),
  .instr_valid           (instr_valid),
  .instr_op              (instr_op),
  .bit_sel               (bit_sel),
  .offset_k              (offset_k),
  .next_is_long          (next_is_long),
  .gp_reg_data           (gp_reg_data),
  .io_reg_data           (io_reg_data),
  .status_flags_register (status_flags_register),
  .pc                    (pc),
  .busy                  (busy),
  .done                  (done)
);

// file: tb.sv
// Self-checking testbench of the skip and branch unit.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, rst_n = 0, v = 0, lg = 0, fwe = 0;
  logic [2:0] op = 0, b = 0;
  logic [6:0] k = 0;
  logic [7:0] g = 0, io = 0, fi = 0;
  wire [15:0] pc;
  wire [7:0]  sf;
  wire        busy, done, taken;
  int         n_fail = 0, checks_done = 0;
  csb_cond_ctrl csb_cond_ctrl_i (.clk(clk), .rst_n(rst_n), .instr_valid(v), .instr_op(op), .bit_sel(b),
    .offset_k(k), .next_is_long(lg), .gp_reg_data(g), .io_reg_data(io), .flags_in(fi), .flags_we(fwe),
    .pc(pc), .status_flags_register(sf), .busy(busy), .done(done), .taken(taken));
  // Core clock of 50 ns.
  initial forever #25 clk = ~clk;
  task chk(string s, logic [15:0] e, logic [15:0] x);
    checks_done++;
    if (e !== x) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", s, e, x);
    end
  endtask
  task test_done;
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Issues one instruction with a refused flag write beside it, then judges cost, target and outcome.
  task go(logic [2:0] o, s, logic [6:0] kk, logic l, logic [7:0] gg, ii, logic [15:0] d, int n);
    logic [15:0] p;
    int c;
    @(posedge clk);
    p = pc;
    {op, b, k, lg, g, io, v, fwe, fi} <= {o, s, kk, l, gg, ii, 2'b11, 8'h5a};
    @(posedge clk);
    {v, fwe} <= 2'b00;
    c = 1;
    #1;
    chk("busy", n > 1, busy);
    while (done !== 1'b1 && c < 5) begin
      @(posedge clk);
      #1;
      c++;
    end
    chk("cycles", n, c);
    chk("pc", p + d, pc);
    chk("taken", n > 1, taken);
  endtask
  // Register and I/O bit skips, short and long, taken and not.
  task t_skip;
    go(1, 3, 0, 0, 8'h08, 0, 2, 2);
    go(1, 7, 0, 1, 8'h80, 0, 3, 3);
    go(1, 7, 0, 1, 8'h7f, 0, 1, 1);
    go(2, 0, 0, 0, 0, 8'hfe, 2, 2);
    go(2, 0, 0, 1, 0, 8'h01, 1, 1);
    go(3, 5, 0, 1, 0, 8'h20, 3, 3);
    go(3, 5, 0, 0, 0, 8'hdf, 1, 1);
    chk("flags", 0, sf);
  endtask
  // Flag branches with backward and forward offsets.
  task t_br;
    @(posedge clk);
    {fi, fwe} <= {8'h81, 1'b1};
    @(posedge clk);
    fwe <= 0;
    go(4, 7, 7'h7e, 0, 0, 0, 16'hffff, 2);
    go(4, 1, 7'h05, 0, 0, 0, 1, 1);
    go(5, 1, 7'h3f, 0, 0, 0, 16'h40, 2);
    go(5, 0, 7'h40, 0, 0, 0, 1, 1);
    chk("flags", 8'h81, sf);
  endtask
  // A second request and a flag write during a long skip are both dropped.
  task t_busy;
    logic [15:0] p;
    @(posedge clk);
    p = pc;
    {op, b, lg, g, v} <= {3'h1, 3'h0, 1'b1, 8'h01, 1'b1};
    @(posedge clk);
    {op, fi, fwe} <= {3'h5, 8'h00, 1'b1};
    @(posedge clk);
    {v, fwe} <= 2'b00;
    @(posedge clk);
    #1;
    chk("done", 1, done);
    chk("pc", p + 16'h3, pc);
    @(posedge clk);
    #1;
    chk("done", 0, done);
    chk("busy", 0, busy);
    chk("pc", p + 16'h3, pc);
    chk("flags", 8'h81, sf);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    t_skip();
    t_br();
    t_busy();
    test_done();
  end
  // Watchdog well beyond the few dozen cycles the tests need.
  initial begin
    #20000;
    n_fail++;
    test_done();
  end
endmodule
